// File: rtl/can_mailbox_id_filter_map.svh
// Register map, field positions and reset values for the mailbox identifier filter
`ifndef CAN_MAILBOX_ID_FILTER_MAP_SVH
`define CAN_MAILBOX_ID_FILTER_MAP_SVH

// Word offsets (byte address = 4 * index)
`define MASK_LOW_IDX 8'h00
`define MASK_HIGH_IDX 8'h01
`define MBOX_BASE_IDX 8'h40
`define MASK_RESET 16'h0000
`define MASK_HIGH_RSVD 16'h1C00
// Control byte indexes within a control set, zero based
`define BYTE_LEN 3'h0
`define BYTE_FRAME 3'h4
`define BYTE_ID_TOP 3'h5
`define BYTE_ID_LOW 3'h6
`define BYTE_ID_MID 3'h7
// Control byte 5 fields
`define FRAME_RTR_BIT 4
`define FRAME_IDE_BIT 3
`define UNMAPPED_READ 32'h00000000

`endif

// File: rtl/can_mailbox_id_filter_pkg.sv
// Types shared by the mailbox identifier filter files
package can_mailbox_id_filter_pkg;
	typedef struct packed {
		logic [28:0] id;
		logic extended;
		logic remote;
		logic [3:0] length_code_field;
	} frame_desc_t;
	typedef struct packed {
		logic [15:0] low;
		logic [15:0] high;
	} mask_pair_t;
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_READ_WAIT,
		BUS_DONE
	} bus_state_t;
endpackage

// File: rtl/mailbox_desc_decode.sv
// Decodes one mailbox control set into a frame descriptor
`timescale 1ns/1ps
module mailbox_desc_decode
	import can_mailbox_id_filter_pkg::*;
(
	input wire logic [63:0] i_bytes, // Control bytes 1..8, byte 1 in bits 7:0
	output can_mailbox_id_filter_pkg::frame_desc_t o_desc, // Decoded descriptor
	output wire logic [3:0] o_byte_count // Data bytes, 0..8
);
	`include "can_mailbox_id_filter_map.svh"
	wire logic [7:0] len_b;
	wire logic [7:0] frame_b;
	wire logic [7:0] top_b;
	wire logic [7:0] low_b;
	wire logic [7:0] mid_b;
	assign len_b = i_bytes[8*`BYTE_LEN +: 8];
	assign frame_b = i_bytes[8*`BYTE_FRAME +: 8];
	assign top_b = i_bytes[8*`BYTE_ID_TOP +: 8];
	assign low_b = i_bytes[8*`BYTE_ID_LOW +: 8];
	assign mid_b = i_bytes[8*`BYTE_ID_MID +: 8];
	assign o_desc.id = {top_b, frame_b[7:5], frame_b[1:0], mid_b, low_b};
	assign o_desc.remote = frame_b[`FRAME_RTR_BIT];
	assign o_desc.extended = frame_b[`FRAME_IDE_BIT];
	assign o_desc.length_code_field = len_b[3:0];
	// Same coding serves data and remote frames
	assign o_byte_count = len_b[3] ? 4'h8 : {1'b0, len_b[2:0]};
endmodule // mailbox_desc_decode

// File: rtl/mailbox0_id_match.sv
// Masked identifier compare for mailbox 0
`timescale 1ns/1ps
module mailbox0_id_match
	import can_mailbox_id_filter_pkg::*;
(
	input can_mailbox_id_filter_pkg::frame_desc_t i_ref, // Mailbox 0 descriptor
	input can_mailbox_id_filter_pkg::mask_pair_t i_mask, // Mask registers
	input wire logic [28:0] i_rx_id, // Received identifier
	input wire logic i_rx_ext, // Received frame is extended
	output wire logic o_match // Identifier accepted
);
	wire logic [28:0] dont_care;
	wire logic [28:0] diff;
	wire logic [28:0] std_keep;
	// Mask bit to identifier bit mapping
	assign dont_care[7:0] = i_mask.low[15:8];
	assign dont_care[15:8] = i_mask.low[7:0];
	assign dont_care[17:16] = i_mask.high[9:8];
	assign dont_care[20:18] = i_mask.high[15:13];
	assign dont_care[28:21] = i_mask.high[7:0];
	// Standard format only looks at the top 11 bits
	assign std_keep = i_rx_ext ? {29{1'b1}} : {{11{1'b1}}, 18'h00000};
	assign diff = (i_rx_id ^ i_ref.id) & ~dont_care & std_keep;
	assign o_match = (diff == 29'h00000000) && (i_rx_ext == i_ref.extended);
endmodule // mailbox0_id_match

// File: rtl/can_mailbox_id_filter.sv
// Mailbox control sets, mailbox 0 acceptance masks and Avalon-MM slave
//
// Overview of operation
// - Low mask bits 15:8 drop identifier bits 7:0 and bits 7:0 drop bits 15:8 from compare.
// - High mask bits 15:13, 9:8 and 7:0 drop identifier bits 20:18, 17:16 and 28:21.
// - High mask bits 12:10 read zero and software writes them zero.
// - The masks act only on the identifier match for mailbox 0.
// - Both masks are 16-bit read-write registers that reset to zero.
// - There are 16 mailboxes, each with eight byte-wide control registers.
// - Byte 1 bits 3:0 give the length, 0..7 directly and 1xxx meaning 8.
// - The same length code gives the requested length of a remote frame.
// - Byte 5 bit 4 is zero for a data frame and one for a remote frame.
// - Byte 5 bit 3 is zero for standard and one for extended identifiers.
// - Byte 5 holds identifier 20:18 in bits 7:5, 17:16 in bits 1:0, and a spare bit 2.
// - Byte 6 holds identifier bits 28:21.
// - Byte 7 holds identifier 7:0 and byte 8 holds identifier 15:8.
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module can_mailbox_id_filter
	import can_mailbox_id_filter_pkg::*;
#(
	parameter int NUM_MAILBOXES = 16,
	parameter int BYTES_PER_SET = 8
) (
	input wire logic i_clk_sys, // System clock, 100 MHz
	input wire logic i_resetn, // Async reset, active low
	input wire logic [9:0] i_avs_address, // Word address
	input wire logic i_avs_read, // Read request
	input wire logic i_avs_write, // Write request
	input wire logic [31:0] i_avs_writedata, // Write data
	input wire logic [3:0] i_avs_byteenable, // Byte lanes
	output logic [31:0] o_avs_readdata, // Read data
	output wire logic o_avs_waitrequest, // Stall
	output wire logic [1:0] o_avs_response, // 00 ok, 10 slave error
	input wire logic i_rx_valid, // Received identifier present
	input wire logic [28:0] i_rx_id, // Received identifier
	input wire logic i_rx_ext, // Received frame extended
	input wire logic [3:0] i_desc_sel, // Mailbox to describe
	output can_mailbox_id_filter_pkg::frame_desc_t o_desc, // Selected descriptor
	output logic [3:0] o_desc_bytes, // Selected data byte count
	output logic o_mbox0_store // Store to mailbox 0 strobe
);
	import can_mailbox_id_filter_pkg::*;
	`include "can_mailbox_id_filter_map.svh"

	initial begin
		if (NUM_MAILBOXES != 16 || BYTES_PER_SET != 8) begin
			$error("mailbox geometry must be 16 sets of 8 bytes");
		end
	end

	// ************************************************************
	// Storage
	// ************************************************************
	// Control sets are RAM with no reset: contents unknown until written
	logic [7:0] ctrl_mem [0:NUM_MAILBOXES*BYTES_PER_SET-1];
	mask_pair_t mask;
	bus_state_t bus_state;
	bus_state_t next_bus_state;
	logic [1:0] rsp;

	// ************************************************************
	// Address decode
	// ************************************************************
	wire logic hit_low;
	wire logic hit_high;
	wire logic hit_mbox;
	wire logic [6:0] mbox_word;
	wire logic [3:0] mbox_num;
	wire logic word_half;
	wire logic [6:0] byte_base;
	wire logic bus_req;
	assign hit_low = (i_avs_address == {2'b00, `MASK_LOW_IDX});
	assign hit_high = (i_avs_address == {2'b00, `MASK_HIGH_IDX});
	assign mbox_word = 7'(i_avs_address - {2'b00, `MBOX_BASE_IDX});
	// Each control set spans two words: bytes 1..4 then bytes 5..8
	assign hit_mbox = (i_avs_address >= {2'b00, `MBOX_BASE_IDX})
		&& (i_avs_address < 10'({2'b00, `MBOX_BASE_IDX} + 10'(2 * NUM_MAILBOXES)));
	assign mbox_num = mbox_word[4:1];
	assign word_half = mbox_word[0];
	assign byte_base = {mbox_num, word_half, 2'b00};
	assign bus_req = i_avs_read || i_avs_write;

	// ************************************************************
	// Bus handshake
	// ************************************************************
	// Reads wait one cycle for the RAM; writes complete at once
	always_comb begin
		next_bus_state = bus_state;
		case (bus_state)
			BUS_IDLE: begin
				if (i_avs_read) begin
					next_bus_state = BUS_READ_WAIT;
				end
			end
			BUS_READ_WAIT: next_bus_state = BUS_IDLE;
			BUS_DONE: next_bus_state = BUS_IDLE;
			default: next_bus_state = BUS_IDLE;
		endcase
	end
	assign o_avs_waitrequest = i_avs_read ? (bus_state != BUS_READ_WAIT) : 1'b0;
	assign o_avs_response = rsp;

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// ************************************************************
	// Mask registers
	// ************************************************************
	wire logic [15:0] mask_wr_bits;
	wire logic [15:0] mask_lane;
	assign mask_lane = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	assign mask_wr_bits = i_avs_writedata[15:0];
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			mask.low <= `MASK_RESET;
			mask.high <= `MASK_RESET;
		end else if (i_avs_write) begin
			if (hit_low) begin
				mask.low <= (mask.low & ~mask_lane) | (mask_wr_bits & mask_lane);
			end
			if (hit_high) begin
				// Reserved bits never store
				mask.high <= ((mask.high & ~mask_lane) | (mask_wr_bits & mask_lane))
					& ~`MASK_HIGH_RSVD;
			end
		end
	end

	// ************************************************************
	// Control set RAM write and read
	// ************************************************************
	// One writer process keeps the RAM single-driven
	wire logic [3:0] lane_we;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign lane_we[g] = i_avs_write && hit_mbox && i_avs_byteenable[g];
		end
	endgenerate
	always_ff @(posedge i_clk_sys) begin
		for (int l = 0; l < 4; l++) begin
			if (lane_we[l]) begin
				ctrl_mem[byte_base + 7'(l)] <= i_avs_writedata[8*l +: 8];
			end
		end
	end

	wire logic [31:0] mbox_rd_word;
	wire logic [31:0] rd_mux;
	assign mbox_rd_word = {ctrl_mem[byte_base + 7'd3], ctrl_mem[byte_base + 7'd2],
		ctrl_mem[byte_base + 7'd1], ctrl_mem[byte_base]};
	assign rd_mux = hit_low ? {16'h0000, mask.low} :
		hit_high ? {16'h0000, mask.high & ~`MASK_HIGH_RSVD} :
		hit_mbox ? mbox_rd_word : `UNMAPPED_READ;

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_avs_readdata <= 32'h00000000;
			rsp <= 2'b00;
		end else if (bus_req && bus_state == BUS_IDLE) begin
			o_avs_readdata <= i_avs_read ? rd_mux : o_avs_readdata;
			rsp <= (hit_low || hit_high || hit_mbox) ? 2'b00 : 2'b10;
		end
	end

	// ************************************************************
	// Descriptor view
	// ************************************************************
	logic [63:0] sel_bytes;
	logic [63:0] mb0_bytes;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			sel_bytes[8*i +: 8] = ctrl_mem[{i_desc_sel, 3'(i)}];
			mb0_bytes[8*i +: 8] = ctrl_mem[7'(i)];
		end
	end

	frame_desc_t sel_desc;
	frame_desc_t mb0_desc;
	wire logic [3:0] sel_count;
	mailbox_desc_decode u_sel_decode (
		.i_bytes(sel_bytes),
		.o_desc(sel_desc),
		.o_byte_count(sel_count)
	);
	mailbox_desc_decode u_mb0_decode (
		.i_bytes(mb0_bytes),
		.o_desc(mb0_desc),
		.o_byte_count()
	);

	// ************************************************************
	// Mailbox 0 acceptance
	// ************************************************************
	wire logic id_match;
	mailbox0_id_match u_match (
		.i_ref(mb0_desc),
		.i_mask(mask),
		.i_rx_id(i_rx_id),
		.i_rx_ext(i_rx_ext),
		.o_match(id_match)
	);

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_desc <= '0;
			o_desc_bytes <= 4'h0;
			o_mbox0_store <= 1'b0;
		end else begin
			o_desc <= sel_desc;
			o_desc_bytes <= sel_count;
			o_mbox0_store <= i_rx_valid && id_match;
		end
	end
endmodule // can_mailbox_id_filter

// File: verif/mbox_filter_chk.sv
// Port assertions for the mailbox identifier filter
`timescale 1ns/1ps
module mbox_filter_chk
	import can_mailbox_id_filter_pkg::*;
#(parameter int NUM_MAILBOXES = 16) (
	input wire logic i_clk_sys, // Clock
	input wire logic i_resetn, // Reset, active low
	input wire logic [9:0] i_avs_address, // Word address
	input wire logic i_avs_read, // Read
	input wire logic i_avs_write, // Write
	input wire logic [31:0] o_avs_readdata, // Read data
	input wire logic o_avs_waitrequest, // Stall
	input wire logic [1:0] o_avs_response, // Response
	input wire logic i_rx_valid, // Identifier present
	input can_mailbox_id_filter_pkg::frame_desc_t o_desc, // Descriptor
	input wire logic [3:0] o_desc_bytes, // Byte count
	input wire logic o_mbox0_store // Store strobe
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	wire rd_done = i_avs_read && !o_avs_waitrequest;
	wire unmapped = i_avs_address >= 10'(64 + 2 * NUM_MAILBOXES);
	a_store_has_cause: assert property (o_mbox0_store |-> $past(i_rx_valid))
		else $error("store strobe without received identifier");
	a_store_one_cycle: assert property (o_mbox0_store && !i_rx_valid |=> !o_mbox0_store)
		else $error("store strobe longer than one cycle");
	a_len_full: assert property (o_desc.length_code_field[3] |-> o_desc_bytes == 4'h8)
		else $error("length code 1xxx not eight bytes");
	a_len_direct: assert property (!o_desc.length_code_field[3] |->
		o_desc_bytes == {1'b0, o_desc.length_code_field[2:0]})
		else $error("length code below eight decoded wrongly");
	a_write_no_wait: assert property (i_avs_write |-> !o_avs_waitrequest)
		else $error("write stalled");
	a_read_one_wait: assert property (i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("read stalled more than one cycle");
	a_rsvd_read_zero: assert property (rd_done && i_avs_address == 10'h001 |->
		o_avs_readdata[31:16] == 16'h0000 && o_avs_readdata[12:10] == 3'h0)
		else $error("reserved mask bits not zero");
	a_unmapped_err: assert property (rd_done && unmapped |->
		o_avs_readdata == 32'h00000000 && o_avs_response == 2'b10)
		else $error("access beyond sixteen mailboxes not refused");
endmodule // mbox_filter_chk
bind can_mailbox_id_filter mbox_filter_chk #(.NUM_MAILBOXES(NUM_MAILBOXES)) u_chk (
	.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
	.i_rx_valid(i_rx_valid), .o_desc(o_desc), .o_desc_bytes(o_desc_bytes),
	.o_mbox0_store(o_mbox0_store));

// File: verif/can_node_model.sv
// Remote node model that delivers received identifiers
`timescale 1ns/1ps
module can_node_model (
	input wire logic i_clk_sys, // Clock
	output logic o_rx_valid, // Identifier present
	output logic [28:0] o_rx_id, // Identifier
	output logic o_rx_ext // Extended format
);
	initial begin
		o_rx_valid = 1'b0;
		o_rx_id = '0;
		o_rx_ext = 1'b0;
	end
	// Fields inverted outside a frame so a stale value never matches
	task automatic send(input logic [28:0] id, input logic ext, input int gap);
		repeat (gap) @(posedge i_clk_sys);
		o_rx_valid <= 1'b1;
		o_rx_id <= id;
		o_rx_ext <= ext;
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b0;
		o_rx_id <= ~id;
		o_rx_ext <= ~ext;
	endtask
endmodule // can_node_model

// File: verif/tb.sv
// Self-checking bench for the mailbox identifier filter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
	import can_mailbox_id_filter_pkg::*;
	logic clk, rstn = 0, rd = 0, wr = 0, rex;
	logic [9:0] adr = '0;
	logic [31:0] wdat = '0, rdat, got, lf = 32'h1D564A65;
	logic [3:0] sel = '0, nby;
	logic [28:0] rid, dc, cm;
	logic [15:0] ml, mh;
	logic [7:0] mb [16][8];
	wire logic wt, st, rxv, rxe;
	wire logic [1:0] rsp;
	logic [1:0] grsp;
	wire logic [28:0] rxid;
	frame_desc_t desc, rf;
	int n_mismatch = 0, compares = 0, cyc = 0;
	can_mailbox_id_filter DUT (.i_clk_sys(clk), .i_resetn(rstn), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wt), .o_avs_response(rsp), .i_rx_valid(rxv),
		.i_rx_id(rxid), .i_rx_ext(rxe), .i_desc_sel(sel), .o_desc(desc), .o_desc_bytes(nby),
		.o_mbox0_store(st));
	can_node_model node (.i_clk_sys(clk), .o_rx_valid(rxv), .o_rx_id(rxid), .o_rx_ext(rxe));
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
	endfunction
	function automatic frame_desc_t mdl(input int m);
		frame_desc_t f;
		f.id = {mb[m][5], mb[m][4][7:5], mb[m][4][1:0], mb[m][7], mb[m][6]};
		f.extended = mb[m][4][3];
		f.remote = mb[m][4][4];
		f.length_code_field = mb[m][0][3:0];
		return f;
	endfunction
	task automatic stop_test;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wt !== 1'b0);
		got = rdat;
		grsp = rsp;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic put_set(input int m);
		bus(1, 10'(64 + 2 * m), {mb[m][3], mb[m][2], mb[m][1], mb[m][0]});
		bus(1, 10'(65 + 2 * m), {mb[m][7], mb[m][6], mb[m][5], mb[m][4]});
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		bus(0, 10'h000, 0); `CHK("mask_low", 32'h0, got)
		bus(0, 10'h001, 0); `CHK("mask_high", 32'h0, got)
		for (int i = 0; i < 4; i++) begin
			lf = nxt(lf);
			bus(1, 10'h000, lf);
			bus(0, 10'h000, 0); `CHK("mask_low", {16'h0, lf[15:0]}, got)
			`CHK("mask_rsp", 2'b00, grsp)
			bus(1, 10'h001, ~lf & 32'h0000E3FF);
			bus(0, 10'h001, 0); `CHK("mask_high", {16'h0, ~lf[15:0] & 16'hE3FF}, got)
		end
		bus(1, 10'h060, lf);
		bus(0, 10'h060, 0); `CHK("unmapped", 32'h0, got)
		`CHK("unmapped_rsp", 2'b10, grsp)
		for (int m = 0; m < 16; m++) begin
			for (int k = 0; k < 8; k++) begin
				lf = nxt(lf);
				mb[m][k] = lf[7:0];
			end
			mb[m][0][3:0] = m[3:0];
			put_set(m);
			bus(0, 10'(64 + 2 * m), 0); `CHK("set_lo", {mb[m][3], mb[m][2], mb[m][1], mb[m][0]}, got)
			bus(0, 10'(65 + 2 * m), 0); `CHK("set_hi", {mb[m][7], mb[m][6], mb[m][5], mb[m][4]}, got)
			@(posedge clk) sel <= m[3:0];
			@(posedge clk) #1;
			`CHK("desc", mdl(m), desc)
			`CHK("bytes", (m > 7) ? 4'h8 : m[3:0], nby)
		end
		for (int i = 0; i < 48; i++) begin
			lf = nxt(lf);
			ml = lf[15:0] & lf[31:16];
			mh = (lf[31:16] ^ lf[15:0]) & 16'hE3FF;
			bus(1, 10'h000, {16'h0, ml});
			bus(1, 10'h001, {16'h0, mh});
			lf = nxt(lf);
			mb[0][4] = lf[7:0];
			put_set(0);
			rf = mdl(0);
			dc = {mh[7:0], mh[15:13], mh[9:8], ml[7:0], ml[15:8]};
			cm = rf.extended ? ~dc : ~dc & 29'h1FFC0000;
			lf = nxt(lf);
			rid = (i % 3 == 0) ? rf.id : rf.id ^ (lf[28:0] & ((i % 3 == 1) ? dc : '1));
			rex = rf.extended ^ (i % 4 == 3);
			node.send(rid, rex, 1 + i % 3);
			#1;
			`CHK("store", rex == rf.extended && ((rid ^ rf.id) & cm) == 0, st)
		end
		stop_test();
	end
endmodule // tb
